// ### rtl/process_pid_regulator.sv
// Process regulator: feedback and target selection, PID terms, output shaping,
// deviation alarm, feedback window and monitor value, plus the feedback register.
// Assumes settings are static from the drive's parameter store, analog pins are
// asynchronous, and serial and pulse measurements arrive on sys_clk_i.
`include "pid_regs.svh"

module process_pid_regulator
  import pid_pkg::*;
#(
  parameter int CTRL_PERIOD_CYC = `PID_PERIOD_CYC
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire pid_cfg_t cfg_i,
  input wire ain_t analog_pins_i,
  input wire logic [15:0] pulse_freq_i,
  input wire logic ascii_fb_valid_i,
  input wire logic [19:0] ascii_fb_data_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  output logic [15:0] freq_cmd_o,
  output logic [23:0] feedback_monitor_o,
  output logic deviation_alarm_out_o,
  output logic feedback_window_out_o,
  output logic [4:0] output_terminal_o,
  output logic relay_terminal_o
);

  pid_state_t st;
  pid_state_t next_st;

  function automatic logic signed [47:0] clamp(input logic signed [47:0] v, input logic signed [47:0] lo,
                                               input logic signed [47:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  //////////////////////////////////////////////////////////////////////////////

  // All arithmetic is in 0.01% of maximum frequency; 48 bits keep products safe
  always_comb
  begin
    logic signed [47:0] volt;
    logic signed [47:0] curr;
    logic signed [47:0] bip;
    logic signed [47:0] fmax;
    logic signed [47:0] fb;
    logic signed [47:0] tgt;
    logic signed [47:0] base;
    logic signed [47:0] err;
    logic signed [47:0] ff;
    logic signed [47:0] kp;
    logic signed [47:0] ti;
    logic signed [47:0] win;
    logic signed [47:0] imax;
    logic signed [47:0] acc;
    logic signed [47:0] iterm;
    logic signed [47:0] dterm;
    logic signed [47:0] sum;
    logic signed [47:0] out;
    logic signed [47:0] fbpct;
    logic signed [47:0] mag;
    volt = '0;
    curr = '0;
    bip = '0;
    fmax = '0;
    fb = '0;
    tgt = '0;
    base = '0;
    err = '0;
    ff = '0;
    kp = '0;
    ti = '0;
    win = '0;
    imax = '0;
    acc = '0;
    iterm = '0;
    dterm = '0;
    sum = '0;
    out = '0;
    fbpct = '0;
    mag = '0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;

    // Three-stage pin capture; a value counts once the last two stages agree
    next_st.s1 = analog_pins_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.ain = st.s3;
    end

    // An input claimed for feed-forward is withheld from target and feedback
    volt = (cfg_i.feedforward_source_select == `PID_FF_VOLTAGE) ? '0 : 48'(st.ain.volt);
    curr = (cfg_i.feedforward_source_select == `PID_FF_CURRENT) ? '0 : 48'(st.ain.curr);
    bip = (cfg_i.feedforward_source_select == `PID_FF_BIPOLAR) ? '0 : 48'(st.ain.bip);
    unique case (cfg_i.feedforward_source_select)
      `PID_FF_VOLTAGE: ff = 48'(st.ain.volt);
      `PID_FF_CURRENT: ff = 48'(st.ain.curr);
      `PID_FF_BIPOLAR: ff = 48'(st.ain.bip);
      default: ff = '0;
    endcase

    // Zero maximum frequency would divide by zero; treat it as the smallest step
    fmax = (cfg_i.max_frequency == 16'h0000) ? 48'sd1 : 48'(cfg_i.max_frequency);

    // Feedback source
    unique case (cfg_i.feedback_source_select)
      `PID_FB_CURRENT: fb = curr;
      `PID_FB_VOLTAGE: fb = volt;
      `PID_FB_SERIAL:
      begin
        if (cfg_i.serial_protocol_select == `PID_PROTO_MODBUS)
        begin
          fb = 48'(st.fb_reg);
        end
        else
        begin
          fb = clamp(48'(st.ascii_hz) * `PID_FULL_SCALE / fmax, '0, `PID_FULL_SCALE);
        end
      end
      `PID_FB_PULSE: fb = clamp(48'(pulse_freq_i) * `PID_FULL_SCALE / fmax, '0, `PID_FULL_SCALE);
      `PID_FB_CALC: fb = (volt + curr) / 48'sd2;
      default: fb = '0;
    endcase

    // Target: terminal block ignores the analog pick and skips the feedback input, except computed feedback, where voltage is still taken
    if (cfg_i.frequency_source_select == `PID_FS_TERMINAL)
    begin
      base = (cfg_i.feedback_source_select == `PID_FB_VOLTAGE) ? curr : volt;
      if (cfg_i.feedback_source_select == `PID_FB_CURRENT || cfg_i.feedback_source_select == `PID_FB_VOLTAGE
          || cfg_i.feedback_source_select == `PID_FB_CALC)
      begin
        unique case (cfg_i.bipolar_input_select)
          `PID_BI_NONREV: tgt = clamp(base + bip, '0, `PID_FULL_SCALE);
          `PID_BI_REV: tgt = clamp(base + bip, -`PID_FULL_SCALE, `PID_FULL_SCALE);
          default: tgt = base;
        endcase
      end
      else
      begin
        tgt = volt;
      end
    end
    else
    begin
      tgt = 48'(cfg_i.target_digital);
    end

    // Deviation, optionally inverted for reverse-acting sensors
    err = tgt - fb;
    if (cfg_i.deviation_polarity_invert == `PID_POL_INVERT)
    begin
      err = -err;
    end

    // Control step once per period
    if (st.tick >= 24'(CTRL_PERIOD_CYC - 1))
    begin
      next_st.tick = '0;
      kp = 48'(cfg_i.proportional_gain);
      ti = 48'(cfg_i.integral_time) * 48'sd1000;
      // Integral is accumulated unscaled so small deviations are not truncated away
      if (ti != '0)
      begin
        imax = `PID_FULL_SCALE * ti;
        acc = clamp(st.integ + kp * err * `PID_PERIOD_MS, -imax, imax);
        iterm = acc / ti;
      end
      dterm = kp * 48'(cfg_i.derivative_gain) * (err - 48'(st.err_prev)) / `PID_PERIOD_MS;
      sum = kp * err / 48'sd10 + iterm + dterm + ff;
      next_st.integ = acc;
      next_st.err_prev = 32'(clamp(err, -48'sd2147483647, 48'sd2147483647));
      unique case (cfg_i.regulator_enable_select)
        `PID_EN_NORMAL:
        begin
          out = sum;
          if (cfg_i.output_variation_range != 10'h000)
          begin
            win = 48'(cfg_i.output_variation_range) * 48'sd10;
            out = clamp(out, tgt - win, tgt + win);
          end
          out = clamp(out, '0, `PID_FULL_SCALE);
        end
        `PID_EN_INVERT:
        begin
          out = (sum < 0) ? -sum : sum;
          out = clamp(out, '0, `PID_FULL_SCALE);
        end
        default:
        begin
          out = clamp(tgt, '0, `PID_FULL_SCALE);
          next_st.integ = '0;
        end
      endcase
      next_st.freq_cmd = 16'(out * fmax / `PID_FULL_SCALE);
    end
    else
    begin
      next_st.tick = st.tick + 24'h000001;
    end

    // Deviation alarm: level is 0.1% steps over the target range
    mag = (err < 0) ? -err : err;
    next_st.alarm = (cfg_i.regulator_enable_select != `PID_EN_OFF)
                    && (mag >= 48'(cfg_i.deviation_alarm_level) * 48'sd10);

    // Feedback window with hysteresis: on below the on level, off above the off level
    fbpct = clamp(fb, '0, `PID_FULL_SCALE);
    if (fbpct < 48'(cfg_i.compare_on_level) * 48'sd10)
    begin
      next_st.feedback_window_out = 1'b1;
    end
    else if (fbpct > 48'(cfg_i.compare_off_level) * 48'sd10)
    begin
      next_st.feedback_window_out = 1'b0;
    end

    // Monitor value in 0.01 units
    next_st.monitor = 24'(fbpct * 48'(cfg_i.monitor_scale_factor) / 48'sd100);

    // Serial ASCII feedback: leading digit 1 marks feedback data
    if (ascii_fb_valid_i && ascii_fb_data_i >= `PID_ASCII_MARK)
    begin
      next_st.ascii_hz = 17'(ascii_fb_data_i - `PID_ASCII_MARK);
    end

    // Feedback register port; a write beyond full scale is held at full scale
    if (reg_wr_i)
    begin
      if (reg_addr_i == `PID_REG_FEEDBACK)
      begin
        next_st.fb_reg = (reg_wdata_i > 16'(`PID_FULL_SCALE)) ? 14'(`PID_FULL_SCALE) : reg_wdata_i[13:0];
        next_st.ack = 1'b1;
      end
      else
      begin
        next_st.err = 1'b1;
      end
    end
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `PID_REG_FEEDBACK && cfg_i.serial_protocol_select == `PID_PROTO_MODBUS)
      begin
        next_st.rdata = 16'(st.fb_reg);
        next_st.ack = 1'b1;
      end
      else
      begin
        next_st.err = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  //////////////////////////////////////////////////////////////////////////////

  // Whole state registers together; reset gives zero command and idle flags
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.fb_reg <= `PID_FB_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////////

  // Register-driven outputs
  assign reg_rdata_o = st.rdata;
  assign reg_ack_o = st.ack;
  assign reg_err_o = st.err;
  assign freq_cmd_o = st.freq_cmd;
  assign feedback_monitor_o = st.monitor;
  assign deviation_alarm_out_o = st.alarm;
  assign feedback_window_out_o = st.feedback_window_out;

  // Terminal routing follows the function code given to each output
  genvar i;
  generate
    for (i = 0; i < 5; i++)
    begin : g_term
      assign output_terminal_o[i] = (cfg_i.output_terminal_function[i] == `PID_FN_DEV_ALARM && st.alarm)
                                    || (cfg_i.output_terminal_function[i] == `PID_FN_FB_WINDOW && st.feedback_window_out);
    end
  endgenerate

  assign relay_terminal_o = (cfg_i.relay_terminal_function == `PID_FN_DEV_ALARM && st.alarm)
                            || (cfg_i.relay_terminal_function == `PID_FN_FB_WINDOW && st.feedback_window_out);

endmodule : process_pid_regulator

// ### rtl/pid_regs.svh
// Constants of the process regulator: setting codes, the feedback register,
// fixed-point scales and the control period. Assumes a 200 MHz system clock.
//
// Contract
// - Output is proportional plus linearly ramping integral plus rate-of-change derivative.
// - Enable code 00 off, 01 normal regulation, 02 regulation with inverted negatives.
// - Normal mode clamps a negative result to a zero hertz command.
// - Code 02 sign-inverts a negative result instead of clamping it.
// - Code 02 bypasses the variation limit and the negative-output stop.
// - Deviation polarity code 01 inverts the deviation before the terms use it.
// - Output held within target plus or minus variation range, maximum frequency 100%.
// - Variation range zero switches the output limit off.
// - Target follows the frequency source; the feedback input is excluded from it, but with computed feedback 10 the terminal target still takes voltage.
// - Feedback source 00 current, 01 voltage, 02 serial, 03 pulse, 10 computed.
// - With terminal-block frequency source the analog input pick is ignored.
// - Bipolar select 00 non-reversible sum, 02 reversible sum, 03 other input alone.
// - Modbus feedback register 0006h, 10000 means 100%, 0.01% resolution.
// - Feedback register reads succeed only when Modbus is the configured protocol.
// - Pulse feedback frequency converts to percent of maximum frequency.
// - Feed-forward input wins over target and feedback use; none disables it.
// - Deviation reaching the alarm level raises every output assigned code 04.
// - Feedback leaving its range raises every output assigned code 31.
// - Separate off and on levels, 0.0 to 100.0%, drive the comparison output.
// - Monitor value equals feedback percent times the display scale factor.
`ifndef PID_REGS_SVH
`define PID_REGS_SVH
`define PID_REG_FEEDBACK 16'h0006
`define PID_FULL_SCALE 32'sd10000
`define PID_EN_OFF 8'h00
`define PID_EN_NORMAL 8'h01
`define PID_EN_INVERT 8'h02
`define PID_FB_CURRENT 8'h00
`define PID_FB_VOLTAGE 8'h01
`define PID_FB_SERIAL 8'h02
`define PID_FB_PULSE 8'h03
`define PID_FB_CALC 8'h10
`define PID_FS_TERMINAL 8'h01
`define PID_BI_NONREV 8'h00
`define PID_BI_REV 8'h02
`define PID_FF_VOLTAGE 8'h01
`define PID_FF_CURRENT 8'h02
`define PID_FF_BIPOLAR 8'h03
`define PID_POL_INVERT 8'h01
`define PID_PROTO_MODBUS 8'h01
`define PID_ASCII_MARK 20'h186A0
`define PID_FN_DEV_ALARM 8'h04
`define PID_FN_FB_WINDOW 8'h1F
`define PID_FB_RESET 14'h0000
`define PID_CLK_NS 5
`define PID_PERIOD_MS 1
`define PID_PERIOD_CYC (`PID_PERIOD_MS * 1000000 / `PID_CLK_NS)
`endif

// ### rtl/pid_pkg.sv
// Types of the process regulator: analog samples, settings and module state.
// Constants live in pid_regs.svh.
package pid_pkg;
  typedef struct packed {
    logic [13:0] volt;
    logic [13:0] curr;
    logic signed [14:0] bip;
  } ain_t;

  typedef struct packed {
    logic [7:0] regulator_enable_select;
    logic [7:0] proportional_gain;
    logic [15:0] integral_time;
    logic [13:0] derivative_gain;
    logic [13:0] monitor_scale_factor;
    logic [7:0] feedback_source_select;
    logic [7:0] deviation_polarity_invert;
    logic [9:0] output_variation_range;
    logic [7:0] feedforward_source_select;
    logic [7:0] frequency_source_select;
    logic [7:0] analog_input_pick;
    logic [7:0] bipolar_input_select;
    logic [9:0] deviation_alarm_level;
    logic [9:0] compare_off_level;
    logic [9:0] compare_on_level;
    logic [7:0] serial_protocol_select;
    logic [4:0][7:0] output_terminal_function;
    logic [7:0] relay_terminal_function;
    logic [15:0] max_frequency;
    logic [13:0] target_digital;
  } pid_cfg_t;

  typedef struct packed {
    ain_t s1;
    ain_t s2;
    ain_t s3;
    ain_t ain;
    logic [23:0] tick;
    logic [13:0] fb_reg;
    logic [16:0] ascii_hz;
    logic signed [47:0] integ;
    logic signed [31:0] err_prev;
    logic [15:0] freq_cmd;
    logic [23:0] monitor;
    logic alarm;
    logic feedback_window_out;
    logic [15:0] rdata;
    logic ack;
    logic err;
  } pid_state_t;
endpackage : pid_pkg

// ### dv/process_pid_regulator_asserts.sv
// Port checks of the process regulator, bound to its top module.
// Assumes static settings and a control period of at least nine cycles.
`include "pid_regs.svh"

module process_pid_regulator_asserts
  import pid_pkg::*;
#(
  parameter int CTRL_PERIOD_CYC = `PID_PERIOD_CYC
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire pid_cfg_t cfg_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_ack_o,
  input wire logic reg_err_o,
  input wire logic [15:0] freq_cmd_o,
  input wire logic deviation_alarm_out_o,
  input wire logic feedback_window_out_o,
  input wire logic [4:0] output_terminal_o,
  input wire logic relay_terminal_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic req;
  logic off;
  // Request and mode helpers
  assign req = reg_wr_i || reg_rd_i;
  assign off = cfg_i.regulator_enable_select == `PID_EN_OFF;
  //////////////////////////////////////////////////////////////////////////////
  AST_ONE_ANSWER: assert property (req |=> reg_ack_o != reg_err_o)
    else $error("register request not answered once");
  AST_NO_STRAY: assert property (!req |=> !reg_ack_o && !reg_err_o)
    else $error("register answer without request");
  AST_UNMAPPED: assert property (req && reg_addr_i != `PID_REG_FEEDBACK |=> reg_err_o)
    else $error("unmapped address accepted");
  AST_READ_REFUSED: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == `PID_REG_FEEDBACK
    && cfg_i.serial_protocol_select != `PID_PROTO_MODBUS |=> reg_err_o)
    else $error("feedback read allowed outside modbus");
  AST_WRITE_TAKEN: assert property (reg_wr_i && reg_addr_i == `PID_REG_FEEDBACK |=> reg_ack_o)
    else $error("feedback write refused");
  AST_OFF_QUIET: assert property (off [*2] |=> !deviation_alarm_out_o)
    else $error("alarm while regulation off");
  AST_FREQ_CEILING: assert property (freq_cmd_o <= cfg_i.max_frequency)
    else $error("command above maximum frequency");
  // Hazard: a step that fires every cycle would track noise, so steps must stay apart
  AST_STEP_HOLD: assert property ($changed(freq_cmd_o) |=> $stable(freq_cmd_o) [*8])
    else $error("command changed between control steps");
  AST_OFF_TARGET: assert property (off && cfg_i.frequency_source_select != `PID_FS_TERMINAL
    && $changed(freq_cmd_o) |-> freq_cmd_o == 16'(32'(cfg_i.target_digital) * cfg_i.max_frequency / 32'd10000))
    else $error("off mode command differs from target");
  AST_TERM_ALARM: assert property (cfg_i.output_terminal_function[0] == `PID_FN_DEV_ALARM
    |-> output_terminal_o[0] == deviation_alarm_out_o)
    else $error("terminal does not follow alarm");
  AST_RELAY_WINDOW: assert property (cfg_i.relay_terminal_function == `PID_FN_FB_WINDOW
    |-> relay_terminal_o == feedback_window_out_o)
    else $error("relay does not follow window");
  // Main scenarios
  cover property (reg_wr_i ##1 reg_ack_o);
  cover property ($rose(deviation_alarm_out_o));
  cover property ($rose(feedback_window_out_o));
endmodule : process_pid_regulator_asserts

bind process_pid_regulator process_pid_regulator_asserts #(.CTRL_PERIOD_CYC(CTRL_PERIOD_CYC)) chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .freq_cmd_o(freq_cmd_o),
  .deviation_alarm_out_o(deviation_alarm_out_o), .feedback_window_out_o(feedback_window_out_o),
  .output_terminal_o(output_terminal_o), .relay_terminal_o(relay_terminal_o));

// ### dv/pid_sensor_model.sv
// Sensor side of the regulator: analog levels, pulse rate and serial frames.
// Assumes the bench sets the levels and calls send_ascii.
module pid_sensor_model
  import pid_pkg::*;
(
  input wire logic sys_clk_i,
  input wire ain_t level_i,
  input wire logic [15:0] pulse_i,
  output ain_t pins_o,
  output logic [15:0] pulse_o,
  output logic ascii_valid_o,
  output logic [19:0] ascii_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins follow the process levels directly
  assign pins_o = level_i;
  assign pulse_o = pulse_i;
  // Idle frame lines
  initial
  begin
    ascii_valid_o = 1'b0;
    ascii_data_o = 20'h00000;
  end
  // Outside a frame the word is inverted so stale data never looks valid
  task automatic send_ascii(input logic [19:0] word);
    @(negedge sys_clk_i);
    ascii_valid_o = 1'b1;
    ascii_data_o = word;
    @(negedge sys_clk_i);
    ascii_valid_o = 1'b0;
    ascii_data_o = ~word;
  endtask : send_ascii
endmodule : pid_sensor_model

// ### dv/process_pid_regulator_test.sv
// Self-checking bench of the process regulator: a table of regulation cases,
// then register, serial, feed-forward, terminal target and integral tests.
// Assumes pid_regs.svh on the include path and the sensor model beside it.
`include "pid_regs.svh"

module process_pid_regulator_test
  import pid_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER = 20;
  typedef struct packed {
    logic [7:0] en, pol, fbs;
    logic [9:0] rng;
    logic [13:0] tgt;
    logic [15:0] out;
    logic [23:0] mon;
    logic al, win;
  } row_t;
  logic sys_clk, rst_n, wr, rd, fb_v, al_o, win_o, ack, err, relay;
  logic [15:0] addr, wdata, rdata, pulse, pulse_p, freq, f1;
  logic [19:0] fb_d;
  logic [23:0] mon;
  logic [4:0] term;
  pid_cfg_t cfg;
  ain_t lv, pins;
  int miscompares = 0;
  int checks = 0;
  // Feedback: current 5000, voltage 1000, computed 3000, pulse 2500; gain 1.0
  row_t rows [11] = '{
    '{8'h00, 8'h00, 8'h00, 10'h000, 14'h0FA0, 16'h0FA0, 24'h002710, 1'b0, 1'b0},
    '{8'h01, 8'h00, 8'h00, 10'h000, 14'h2328, 16'h0FA0, 24'h002710, 1'b1, 1'b0},
    '{8'h01, 8'h00, 8'h00, 10'h000, 14'h07D0, 16'h0000, 24'h002710, 1'b1, 1'b0},
    '{8'h02, 8'h00, 8'h00, 10'h000, 14'h07D0, 16'h0BB8, 24'h002710, 1'b1, 1'b0},
    '{8'h01, 8'h01, 8'h00, 10'h000, 14'h07D0, 16'h0BB8, 24'h002710, 1'b1, 1'b0},
    '{8'h01, 8'h00, 8'h00, 10'h064, 14'h1770, 16'h1388, 24'h002710, 1'b0, 1'b0},
    '{8'h01, 8'h00, 8'h00, 10'h000, 14'h1770, 16'h03E8, 24'h002710, 1'b0, 1'b0},
    '{8'h02, 8'h00, 8'h00, 10'h064, 14'h1770, 16'h03E8, 24'h002710, 1'b0, 1'b0},
    '{8'h01, 8'h00, 8'h01, 10'h000, 14'h1770, 16'h1388, 24'h0007D0, 1'b1, 1'b1},
    '{8'h01, 8'h00, 8'h10, 10'h000, 14'h1770, 16'h0BB8, 24'h001770, 1'b1, 1'b1},
    '{8'h01, 8'h00, 8'h03, 10'h000, 14'h1770, 16'h0DAC, 24'h001388, 1'b1, 1'b1}};
  logic [7:0] bfb [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] bsel [4] = '{8'h00, 8'h02, 8'h03, 8'h03};
  logic [15:0] bexp [4] = '{16'h07D0, 16'h07D0, 16'h0FA0, 16'h0FA0};
  //////////////////////////////////////////////////////////////////////////////
  pid_sensor_model sensor (.sys_clk_i(sys_clk), .level_i(lv), .pulse_i(pulse), .pins_o(pins), .pulse_o(pulse_p),
    .ascii_valid_o(fb_v), .ascii_data_o(fb_d));
  process_pid_regulator #(.CTRL_PERIOD_CYC(PER)) uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cfg_i(cfg),
    .analog_pins_i(pins), .pulse_freq_i(pulse_p), .ascii_fb_valid_i(fb_v), .ascii_fb_data_i(fb_d),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .reg_err_o(err), .freq_cmd_o(freq), .feedback_monitor_o(mon), .deviation_alarm_out_o(al_o),
    .feedback_window_out_o(win_o), .output_terminal_o(term), .relay_terminal_o(relay));
  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk_val
  // Three steps cover the analog sampling delay and one full derivative settle
  task automatic settle();
    repeat (3 * PER) @(negedge sys_clk);
  endtask : settle
  // Request taken at the next rising edge; the answer stands only until the edge after
  task automatic reg_op(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e_err);
    @(negedge sys_clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    chk_val("reg_err", e_err, err);
    chk_val("reg_ack", !e_err, ack);
    wr = 1'b0;
    rd = 1'b0;
  endtask : reg_op
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // Watchdog against a hung sequence
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    cfg = '0;
    cfg.max_frequency = 16'h2710;
    cfg.frequency_source_select = 8'h02;
    cfg.proportional_gain = 8'h0A;
    cfg.monitor_scale_factor = 14'h00C8;
    cfg.deviation_alarm_level = 10'h12C;
    cfg.compare_on_level = 10'h0C8;
    cfg.compare_off_level = 10'h190;
    cfg.output_terminal_function[0] = `PID_FN_DEV_ALARM;
    cfg.output_terminal_function[1] = `PID_FN_FB_WINDOW;
    cfg.relay_terminal_function = `PID_FN_FB_WINDOW;
    cfg.serial_protocol_select = `PID_PROTO_MODBUS;
    lv = '{volt: 14'h03E8, curr: 14'h1388, bip: 15'h0000};
    pulse = 16'h09C4;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    repeat (2) @(negedge sys_clk);
    chk_val("reset_cmd", 24'h000000, freq);
    rst_n = 1'b1;
    reg_op(1'b0, `PID_REG_FEEDBACK, 16'h0000, 1'b0);
    chk_val("reset_rdata", 24'h000000, rdata);
    foreach (rows[i])
    begin
      cfg.regulator_enable_select = rows[i].en;
      cfg.deviation_polarity_invert = rows[i].pol;
      cfg.feedback_source_select = rows[i].fbs;
      cfg.output_variation_range = rows[i].rng;
      cfg.target_digital = rows[i].tgt;
      settle();
      chk_val("freq_cmd", rows[i].out, freq);
      chk_val("monitor", rows[i].mon, mon);
      chk_val("alarm_terminal", rows[i].al, term[0]);
      chk_val("window_relay", rows[i].win, relay);
      chk_val("alarm_out", rows[i].al, al_o);
      chk_val("window_out", rows[i].win, win_o);
      chk_val("window_terminal", rows[i].win, term[1]);
      $display("case %0d done", i);
    end
    cfg.feedback_source_select = `PID_FB_SERIAL;
    reg_op(1'b1, `PID_REG_FEEDBACK, 16'h1388, 1'b0);
    settle();
    chk_val("modbus_cmd", 24'h0003E8, freq);
    reg_op(1'b1, `PID_REG_FEEDBACK, 16'h2EE0, 1'b0);
    reg_op(1'b0, `PID_REG_FEEDBACK, 16'h0000, 1'b0);
    chk_val("modbus_rdata", 24'h002710, rdata);
    reg_op(1'b0, 16'h0007, 16'h0000, 1'b1);
    reg_op(1'b1, 16'h0007, 16'h0001, 1'b1);
    $display("modbus test done");
    cfg.serial_protocol_select = 8'h00;
    reg_op(1'b0, `PID_REG_FEEDBACK, 16'h0000, 1'b1);
    sensor.send_ascii(20'h18894);
    settle();
    chk_val("ascii_cmd", 24'h00157C, freq);
    sensor.send_ascii(20'h002BC);
    settle();
    chk_val("ascii_unmarked", 24'h00157C, freq);
    $display("ascii test done");
    cfg.feedback_source_select = `PID_FB_CURRENT;
    cfg.feedforward_source_select = `PID_FF_VOLTAGE;
    settle();
    chk_val("feedforward_cmd", 24'h0007D0, freq);
    cfg.feedback_source_select = `PID_FB_VOLTAGE;
    settle();
    chk_val("feedforward_priority", 24'h001B58, freq);
    $display("feed-forward test done");
    cfg.feedforward_source_select = 8'h00;
    cfg.frequency_source_select = `PID_FS_TERMINAL;
    cfg.analog_input_pick = 8'hFF;
    cfg.regulator_enable_select = `PID_EN_INVERT;
    lv.bip = 15'h07D0;
    foreach (bsel[j])
    begin
      cfg.feedback_source_select = bfb[j];
      cfg.bipolar_input_select = bsel[j];
      settle();
      chk_val("terminal_target", bexp[j], freq);
    end
    $display("terminal target test done");
    cfg.frequency_source_select = 8'h02;
    cfg.regulator_enable_select = `PID_EN_NORMAL;
    cfg.feedback_source_select = `PID_FB_CURRENT;
    cfg.integral_time = 16'h000A;
    settle();
    f1 = freq;
    repeat (10 * PER) @(negedge sys_clk);
    chk_val("integral_ramp", 24'h00000A, 24'(freq - f1));
    $display("integral test done");
    // Mid-run reset must drop the command and restore the feedback register
    rst_n = 1'b0;
    @(negedge sys_clk);
    chk_val("midrun_reset_cmd", 24'h000000, freq);
    chk_val("midrun_reset_flags", 24'h000000, {term, relay, al_o, win_o});
    rst_n = 1'b1;
    cfg.serial_protocol_select = `PID_PROTO_MODBUS;
    reg_op(1'b0, `PID_REG_FEEDBACK, 16'h0000, 1'b0);
    chk_val("midrun_reset_rdata", 24'h000000, rdata);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : process_pid_regulator_test
